// file: shared/mbr_pkg.sv
// Constants, carriers and state record of the monitor register bank.
package mbr_pkg;
    localparam logic [7:0] A_RES_HI = 8'h07;
    localparam logic [7:0] A_MM_LO  = 8'h08;
    localparam logic [7:0] A_MM_HI  = 8'h17;
    localparam logic [7:0] A_BUFEN  = 8'h19;
    localparam logic [7:0] A_THR_LO = 8'h1a;
    localparam logic [7:0] A_THR_HI = 8'h23;
    localparam logic [7:0] A_FAULT  = 8'h27;
    localparam logic [7:0] A_STAT1  = 8'h28;
    localparam logic [7:0] A_STAT2  = 8'h29;
    localparam logic [7:0] A_UVW    = 8'h2a;
    localparam logic [7:0] A_OVW    = 8'h2b;
    localparam logic [7:0] A_OCW    = 8'h2c;
    localparam logic [7:0] A_KEY    = 8'h2d;
    localparam logic [7:0] A_FOSET  = 8'h2e;
    localparam logic [7:0] A_CHEN   = 8'h2f;
    localparam logic [7:0] A_DGI    = 8'h30;
    localparam logic [7:0] A_DGUV   = 8'h31;
    localparam logic [7:0] A_DGOV   = 8'h32;
    localparam logic [7:0] A_RDW    = 8'h33;
    localparam logic [7:0] A_POST   = 8'h34;
    localparam logic [7:0] A_PKCLR  = 8'h35;
    localparam logic [7:0] A_PKHLD  = 8'h36;
    localparam logic [7:0] A_GPOE   = 8'h37;
    localparam logic [7:0] A_GPLV   = 8'h38;
    localparam logic [7:0] A_REVT   = 8'h39;
    localparam logic [7:0] A_BUFCS  = 8'h3a;
    localparam logic [7:0] A_BUFLV  = 8'h3b;
    localparam logic [7:0] FO_KEY   = 8'ha5;
    localparam int FO_IN = 0, FO_OR = 1, FO_RST = 2;
    localparam int CH_IN_EN = 0, CH_IN_MSK = 1, CH_OR_EN = 2, CH_OR_MSK = 3;
    localparam int UV_UNM = 2, OV_UNM = 3, OC_UNM = 1, BUF_REVSTOP = 2;
    localparam logic [9:0] MIN_RST  = 10'h3ff;
    localparam logic [9:0] MAX_RST  = 10'h000;
    localparam logic [9:0] OVOC_RST = 10'h3ff;
    localparam logic [9:0] UV_RST   = 10'h000;
    localparam logic [2:0] BUFEN_RST = 3'h7;
    localparam logic [5:0] POST_RST  = 6'h19;
    localparam logic [1:0] REVT_RST  = 2'h3;
    localparam logic [5:0] BUF_DEPTH = 6'h32;
    localparam logic [5:0] BUF_LAST  = 6'h31;
    // Sampled channel of bank 0 (input current) and bank 1 (load voltage).
    localparam logic [1:0][1:0] BANK_CH = {2'h3, 2'h0};
    // Comparators: 0 overcurrent, 1 aux undervoltage, 2..4 overvoltage.
    localparam logic [4:0][1:0] CMP_CH = {2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
    localparam logic [3:0][2:0] REV_MULT = {3'h6, 3'h4, 3'h2, 3'h1};
    localparam int CLK_MHZ = 40;
    localparam int REV_UNIT_US = 32;
    localparam int REV_UNIT_CYC = REV_UNIT_US * CLK_MHZ;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mbr_req_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic [9:0] data;
    } mbr_adc_t;

    typedef struct packed {
        logic [4:0]             s1, s2;
        logic [7:0]             rdata;
        logic [3:0][9:0]        res, vmin, vmax;
        logic [4:0][9:0]        thr;
        logic [4:0]             flg, prv;
        logic [2:0]             buf_en;
        logic                   uv_unm, ov_unm, oc_unm;
        logic [7:0]             key;
        logic [1:0]             foset;
        logic [3:0]             chen;
        logic [4:0]             dgl;
        logic [1:0]             rdw;
        logic [5:0]             post;
        logic [3:0]             pkclr, pkhld;
        logic [1:0]             gpoe, gplv, revt;
        logic                   brk_flt, rev_flt, def_flg;
        logic [12:0]            rev_cnt;
        logic [1:0][49:0][9:0]  mem;
        logic [1:0][5:0]        wptr, fill, drain, rptr;
        logic [1:0]             rding, rhalf;
        logic                   in_gate, or_gate, alert_oe_n, alert_o;
        logic [1:0]             gpio_oe_n, gpio_o;
    } mbr_state_t;
endpackage : mbr_pkg

// file: hdl/mbr_monitor.sv
// Monitor register bank: trackers, warnings, history banks and switch control.
// What this block does
// R01 - Force-on bits act only while the unlock key holds 0xA5.
// R02 - Force-on keeps both switches on, ignoring overcurrent and reverse comparators.
// R03 - Keyed write of force-on bit 2 restores all registers; bit self-clears.
// R04 - Enable bits 0 and 2 are master enables; bits 1, 3 mask ON.
// R05 - A master enable overrides the ON masking bit of its switch.
// R06 - Each channel's result register updates when its own conversion completes.
// R07 - Host reads never stall or drop a conversion.
// R08 - New reading below minimum replaces it; above maximum replaces it.
// R09 - Minimums reset to 0x3FF, maximums to 0x000; host may rewrite them.
// R10 - Current and load trackers pause while their history bank is frozen.
// R11 - Clear bits hold a channel's min/max at start values while set.
// R12 - Hold bits freeze a channel's min/max against readings and host writes; clear bits still reset it.
// R13 - Warnings set above overvoltage/overcurrent or below undervoltage thresholds.
// R14 - Thresholds at their reset values leave the comparator inactive.
// R15 - Reading a warning flag register clears its flags.
// R16 - Unmask bits let warning flags drive the alert output low.
// R17 - Each comparator has its own deglitch enable bit.
// R18 - With deglitch, a flag needs two violating conversions in a row.
// R19 - Two history banks of 50 ten-bit samples: input current, load voltage.
// R20 - Write pointer wraps after the last slot; read-out runs oldest to newest.
// R21 - Reading a bank base address streams it; width bit selects upper bytes.
// R22 - Bank stops on enable clear, input switch off, or own read-out; the load bank also stops on oring switch off.
// R23 - After a stop request a bank stores post-stop count more samples.
// R24 - Persistent reverse current stops the load bank and clears its enable.
// R25 - Reverse delay codes 32, 64, 128, 192 us; reset code 11.
// R26 - GPIO enable one gives open-drain output; level zero pulls low.
// R27 - Unused bits of narrow registers ignore writes and read as zero.
// R28 - Host writes 10-bit settings as two bytes, reads upper byte first.
`timescale 1ns/1ps
`default_nettype none
module mbr_monitor #(
    parameter int unsigned REV_UNIT_CYCLES = mbr_pkg::REV_UNIT_CYC
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // Register port from the serial engine.
    input  wire mbr_pkg::mbr_req_t host_req,
    output logic [7:0]            host_rdata,
    // Conversion results.
    input  wire mbr_pkg::mbr_adc_t adc_in,
    // Comparator and pin inputs.
    input  wire logic             on_cmp_pin,
    input  wire logic             reverse_current_pin,
    input  wire logic             breaker_trip_pin,
    input  wire logic [1:0]       gpio_in,
    // Switch drivers and open-drain pins.
    output logic                  input_switch_gate,
    output logic                  oring_switch_gate,
    output logic                  alert_o,
    output logic                  alert_oe_n,
    output logic [1:0]            gpio_o,
    output logic [1:0]            gpio_oe_n
);
    import mbr_pkg::*;

    mbr_state_t  st_q, st_d, init;
    logic        on_s, rev_s, brk_s, key_ok, fo_in, fo_or, rev_hit, soft_rst, bs, bh, lo;
    logic [1:0]  stop, frozen;
    logic [1:0][5:0] oldest;
    logic [4:0]  viol, seen;
    logic [5:0]  bp;
    logic [7:0]  a, wd, off;
    logic [9:0]  tw, d;
    logic [12:0] rev_lim;

    function automatic logic [9:0] put(logic [9:0] old, logic low, logic [7:0] b);
        return low ? {old[9:2], b[1:0]} : {b, old[1:0]};
    endfunction : put

    always_comb begin
        init = '0;
        for (int c = 0; c < 4; c++) begin
            init.vmin[c] = MIN_RST; // [R09]
            init.vmax[c] = MAX_RST;
        end
        for (int k = 0; k < 5; k++) begin
            init.thr[k] = (k == 1) ? UV_RST : OVOC_RST; // [R14]
        end
        init.buf_en     = BUFEN_RST;
        init.post       = POST_RST;
        init.revt       = REVT_RST; // [R25]
        init.def_flg    = 1'b1;
        init.alert_oe_n = 1'b1;
        init.gpio_oe_n  = 2'h3;
    end

    always_comb begin
        st_d     = st_q;
        a        = host_req.addr;
        wd       = host_req.wdata;
        d        = adc_in.data;
        tw       = '0;
        lo       = 1'b0;
        off      = '0;
        bs       = 1'b0;
        bh       = 1'b0;
        bp       = '0;
        soft_rst = 1'b0;
        st_d.s1  = {gpio_in, breaker_trip_pin, reverse_current_pin, on_cmp_pin};
        st_d.s2  = st_q.s1;
        on_s     = st_q.s2[0];
        rev_s    = st_q.s2[1];
        brk_s    = st_q.s2[2];
        key_ok   = (st_q.key == FO_KEY);
        fo_in    = key_ok & st_q.foset[FO_IN]; // [R01]
        fo_or    = key_ok & st_q.foset[FO_OR]; // [R01]
        stop[0]  = !st_q.buf_en[0] | !st_q.in_gate | st_q.rding[0]; // [R22]
        stop[1]  = !st_q.buf_en[1] | !st_q.in_gate | !st_q.or_gate | st_q.rding[1]; // [R22]
        for (int b = 0; b < 2; b++) begin
            frozen[b] = stop[b] & (st_q.drain[b] == '0);
            oldest[b] = (st_q.fill[b] == BUF_DEPTH) ? st_q.wptr[b] : '0; // [R20]
        end
        // Conversions land directly in state; the read path never waits on them.
        if (adc_in.valid) begin
            st_d.res[adc_in.chan] = d; // [R06] [R07]
            if (!(adc_in.chan == BANK_CH[0] && frozen[0]) &&
                !(adc_in.chan == BANK_CH[1] && frozen[1]) &&
                !st_q.pkhld[adc_in.chan]) begin // [R10] [R12]
                if (d < st_q.vmin[adc_in.chan]) st_d.vmin[adc_in.chan] = d; // [R08]
                if (d > st_q.vmax[adc_in.chan]) st_d.vmax[adc_in.chan] = d; // [R08]
            end
        end
        for (int b = 0; b < 2; b++) begin
            if (adc_in.valid && adc_in.chan == BANK_CH[b] && !frozen[b]) begin // [R19]
                st_d.mem[b][st_q.wptr[b]] = d;
                st_d.wptr[b] = (st_q.wptr[b] == BUF_LAST) ? '0 : st_q.wptr[b] + 6'h01; // [R20]
                if (st_q.fill[b] != BUF_DEPTH) st_d.fill[b] = st_q.fill[b] + 6'h01;
                if (stop[b]) st_d.drain[b] = st_q.drain[b] - 6'h01; // [R23]
            end
            if (!stop[b]) st_d.drain[b] = st_q.post; // [R23]
        end
        viol[0] = (d > st_q.thr[0]) && (st_q.thr[0] != OVOC_RST); // [R13] [R14]
        viol[1] = (d < st_q.thr[1]) && (st_q.thr[1] != UV_RST); // [R13] [R14]
        for (int k = 2; k < 5; k++) begin
            viol[k] = (d > st_q.thr[k]) && (st_q.thr[k] != OVOC_RST); // [R13] [R14]
        end
        for (int k = 0; k < 5; k++) begin
            seen[k] = adc_in.valid && adc_in.chan == CMP_CH[k];
            if (seen[k]) st_d.prv[k] = viol[k];
        end
        // Register port. A read of a bank base keeps streaming until another address.
        if ((host_req.rd || host_req.wr) && a != A_BUFCS) st_d.rding[0] = 1'b0; // [R22]
        if ((host_req.rd || host_req.wr) && a != A_BUFLV) st_d.rding[1] = 1'b0; // [R22]
        if (host_req.rd) begin
            case (a)
                A_BUFEN: st_d.rdata = {5'h00, st_q.buf_en}; // [R27]
                A_FAULT: begin
                    st_d.rdata   = {4'h0, st_q.def_flg, st_q.rev_flt, 1'b0, st_q.brk_flt};
                    st_d.rev_flt = 1'b0;
                    st_d.brk_flt = st_q.brk_flt;
                end
                A_STAT1: st_d.rdata = {5'h00, st_q.s2[4:3], on_s};
                A_STAT2: st_d.rdata = {4'h0, st_q.or_gate, st_q.in_gate, !st_q.alert_oe_n, 1'b0};
                A_UVW: begin
                    st_d.rdata  = {5'h00, st_q.uv_unm, 1'b0, st_q.flg[1]};
                    st_d.flg[1] = 1'b0; // [R15]
                end
                A_OVW: begin
                    st_d.rdata    = {4'h0, st_q.ov_unm, st_q.flg[4:2]};
                    st_d.flg[4:2] = 3'h0; // [R15]
                end
                A_OCW: begin
                    st_d.rdata  = {6'h00, st_q.oc_unm, st_q.flg[0]};
                    st_d.flg[0] = 1'b0; // [R15]
                end
                A_KEY:   st_d.rdata = st_q.key;
                A_FOSET: st_d.rdata = {6'h00, st_q.foset};
                A_CHEN:  st_d.rdata = {4'h0, st_q.chen};
                A_DGI:   st_d.rdata = {7'h00, st_q.dgl[0]};
                A_DGUV:  st_d.rdata = {7'h00, st_q.dgl[1]};
                A_DGOV:  st_d.rdata = {5'h00, st_q.dgl[4:2]};
                A_RDW:   st_d.rdata = {6'h00, st_q.rdw};
                A_POST:  st_d.rdata = {2'h0, st_q.post};
                A_PKCLR: st_d.rdata = {4'h0, st_q.pkclr};
                A_PKHLD: st_d.rdata = {4'h0, st_q.pkhld};
                A_GPOE:  st_d.rdata = {6'h00, st_q.gpoe};
                A_GPLV:  st_d.rdata = {6'h00, st_q.gplv};
                A_REVT:  st_d.rdata = {6'h00, st_q.revt};
                A_BUFCS, A_BUFLV: begin
                    bs = (a == A_BUFLV); // [R21]
                    bp = st_q.rding[bs] ? st_q.rptr[bs] : oldest[bs]; // [R20]
                    bh = st_q.rding[bs] & st_q.rhalf[bs];
                    tw = st_q.mem[bs][bp];
                    st_d.rdata = bh ? {6'h00, tw[1:0]} : tw[9:2]; // [R21]
                    st_d.rding[bs] = 1'b1; // [R22]
                    if (st_q.rdw[bs] || bh) begin
                        st_d.rhalf[bs] = 1'b0;
                        st_d.rptr[bs]  = (bp == BUF_LAST) ? '0 : bp + 6'h01;
                    end else begin
                        st_d.rhalf[bs] = 1'b1;
                        st_d.rptr[bs]  = bp;
                    end
                end
                default: begin
                    lo = a[0];
                    if (a <= A_RES_HI) begin
                        tw = st_q.res[a[2:1]];
                    end else if (a <= A_MM_HI) begin
                        off = a - A_MM_LO;
                        tw  = off[1] ? st_q.vmax[off[3:2]] : st_q.vmin[off[3:2]];
                    end else if (a >= A_THR_LO && a <= A_THR_HI) begin
                        off = a - A_THR_LO;
                        lo  = off[0];
                        tw  = st_q.thr[off[3:1]];
                    end
                    st_d.rdata = lo ? {6'h00, tw[1:0]} : tw[9:2]; // [R27]
                end
            endcase
        end
        if (host_req.wr) begin
            st_d.def_flg = 1'b0;
            case (a)
                A_BUFEN: st_d.buf_en = wd[2:0]; // [R27]
                A_UVW:   st_d.uv_unm = wd[UV_UNM];
                A_OVW:   st_d.ov_unm = wd[OV_UNM]; // [R16]
                A_OCW:   st_d.oc_unm = wd[OC_UNM]; // [R16]
                A_KEY:   st_d.key    = wd;
                A_FOSET: begin
                    st_d.foset = wd[1:0];
                    soft_rst   = key_ok && wd[FO_RST]; // [R03]
                end
                A_CHEN: begin
                    st_d.chen = wd[3:0];
                    if (!wd[CH_IN_EN]) st_d.brk_flt = 1'b0;
                end
                A_DGI:   st_d.dgl[0]   = wd[0]; // [R17]
                A_DGUV:  st_d.dgl[1]   = wd[0]; // [R17]
                A_DGOV:  st_d.dgl[4:2] = wd[2:0]; // [R17]
                A_RDW:   st_d.rdw      = wd[1:0]; // [R21]
                A_POST:  st_d.post     = wd[5:0];
                A_PKCLR: st_d.pkclr    = wd[3:0];
                A_PKHLD: st_d.pkhld    = wd[3:0];
                A_GPOE:  st_d.gpoe     = wd[1:0];
                A_GPLV:  st_d.gplv     = wd[1:0];
                A_REVT:  st_d.revt     = wd[1:0];
                default: begin
                    if (a >= A_MM_LO && a <= A_MM_HI) begin
                        off = a - A_MM_LO;
                        if (!st_q.pkhld[off[3:2]]) begin // [R12]
                            if (off[1]) begin
                                st_d.vmax[off[3:2]] = put(st_d.vmax[off[3:2]], off[0], wd); // [R09]
                            end else begin
                                st_d.vmin[off[3:2]] = put(st_d.vmin[off[3:2]], off[0], wd); // [R09]
                            end
                        end
                    end else if (a >= A_THR_LO && a <= A_THR_HI) begin
                        off = a - A_THR_LO;
                        st_d.thr[off[3:1]] = put(st_q.thr[off[3:1]], off[0], wd);
                    end
                end
            endcase
        end
        for (int c = 0; c < 4; c++) begin
            if (st_q.pkclr[c]) begin
                st_d.vmin[c] = MIN_RST; // [R11]
                st_d.vmax[c] = MAX_RST; // [R11]
            end
        end
        // Flag sets come after the read clear so a coincident event survives.
        for (int k = 0; k < 5; k++) begin
            if (seen[k] && viol[k] && (!st_q.dgl[k] || st_q.prv[k])) st_d.flg[k] = 1'b1; // [R18]
        end
        rev_lim = 13'(REV_UNIT_CYCLES * REV_MULT[st_q.revt]); // [R25]
        rev_hit = rev_s && !fo_or && (st_q.rev_cnt + 13'h0001 == rev_lim);
        if (rev_s && !fo_or) begin // [R02]
            if (st_q.rev_cnt != rev_lim) st_d.rev_cnt = st_q.rev_cnt + 13'h0001;
        end else begin
            st_d.rev_cnt = '0;
        end
        if (rev_hit) begin
            st_d.rev_flt = 1'b1;
            if (st_q.buf_en[BUF_REVSTOP]) st_d.buf_en[1] = 1'b0; // [R24]
        end
        if (brk_s && !fo_in) st_d.brk_flt = 1'b1; // [R02]
        // A set master enable turns its switch on whatever the ON comparator or mask says.
        st_d.in_gate = fo_in | ((st_q.chen[CH_IN_EN] | (on_s & !st_q.chen[CH_IN_MSK])) &
                       !st_q.brk_flt); // [R02] [R04] [R05]
        st_d.or_gate = fo_or | ((st_q.chen[CH_OR_EN] | (on_s & !st_q.chen[CH_OR_MSK])) &
                       !rev_s & !st_q.rev_flt); // [R02] [R04] [R05]
        st_d.alert_oe_n = !(st_q.brk_flt | st_q.rev_flt | (st_q.oc_unm & st_q.flg[0]) |
                          (st_q.uv_unm & st_q.flg[1]) | (st_q.ov_unm & |st_q.flg[4:2])); // [R16]
        for (int g = 0; g < 2; g++) begin
            st_d.gpio_oe_n[g] = !(st_q.gpoe[g] & !st_q.gplv[g]); // [R26]
        end
        st_d.alert_o = 1'b0;
        st_d.gpio_o  = 2'h0;
        if (soft_rst) st_d = init; // [R03]
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= init;
        end else begin
            st_q <= st_d;
        end
    end

    assign host_rdata        = st_q.rdata;
    assign input_switch_gate = st_q.in_gate;
    assign oring_switch_gate = st_q.or_gate;
    assign alert_o           = st_q.alert_o;
    assign alert_oe_n        = st_q.alert_oe_n;
    assign gpio_o            = st_q.gpio_o;
    assign gpio_oe_n         = st_q.gpio_oe_n;

    a_key_gates_force: assert property (@(posedge sys_clk) disable iff (reset) // [R01]
        (st_q.key != FO_KEY && !st_q.chen[CH_IN_EN] && st_q.chen[CH_IN_MSK])
        |=> !input_switch_gate)
        else $error("input switch on without key or enable");
    a_force_keeps_on: assert property (@(posedge sys_clk) disable iff (reset) // [R02]
        (fo_in && !soft_rst) |=> input_switch_gate)
        else $error("force-on did not hold input switch");
    a_soft_reset_all: assert property (@(posedge sys_clk) disable iff (reset) // [R03]
        (host_req.wr && a == A_FOSET && wd[FO_RST] && key_ok)
        |=> (st_q.key == 8'h00 && st_q.foset == 2'h0 && st_q.post == POST_RST))
        else $error("keyed reset did not restore registers");
    a_master_wins: assert property (@(posedge sys_clk) disable iff (reset) // [R05]
        (st_q.chen[CH_OR_EN] && st_q.chen[CH_OR_MSK] && !rev_s && !st_q.rev_flt && !soft_rst)
        |=> oring_switch_gate)
        else $error("oring switch off with master enable on");
    a_min_tracks: assert property (@(posedge sys_clk) disable iff (reset) // [R08]
        (adc_in.valid && adc_in.chan == 2'h1 && adc_in.data < st_q.vmin[1] &&
         !st_q.pkclr[1] && !st_q.pkhld[1] && !host_req.wr && !soft_rst)
        |=> st_q.vmin[1] == $past(adc_in.data))
        else $error("minimum not replaced by lower reading");
    a_read_clears: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
        (host_req.rd && a == A_OCW && !seen[0] && !soft_rst) |=> !st_q.flg[0])
        else $error("overcurrent flag survived its read");
    a_idle_threshold: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
        (st_q.thr[0] == OVOC_RST && !st_q.flg[0]) |=> !st_q.flg[0])
        else $error("default threshold raised a warning");
    a_frozen_bank: assert property (@(posedge sys_clk) disable iff (reset) // [R23]
        (frozen[0] && !soft_rst) |=> $stable(st_q.wptr[0]))
        else $error("frozen bank kept writing");
    a_rev_stops_lv: assert property (@(posedge sys_clk) disable iff (reset) // [R24]
        (rev_hit && st_q.buf_en[BUF_REVSTOP] && !soft_rst) |=> (!st_q.buf_en[1] && stop[1]))
        else $error("reverse fault did not stop load bank");
    a_gpio_pulls: assert property (@(posedge sys_clk) disable iff (reset) // [R26]
        (st_q.gpoe[0] && !st_q.gplv[0] && !soft_rst) |=> (!gpio_oe_n[0] && !gpio_o[0]))
        else $error("gpio not pulled low in output mode");
endmodule : mbr_monitor
`default_nettype wire

// file: verification/mbr_host_model.sv
// Host model issuing register byte accesses on the serial engine port.
`timescale 1ns/1ps
`default_nettype none
module mbr_host_model (
    // Clock.
    input  wire logic         sys_clk,
    // Register port.
    output var mbr_pkg::mbr_req_t host_req,
    input  wire logic [7:0]   host_rdata
);
    import mbr_pkg::*;
    initial host_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2 host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk);
        #2 host_req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #2 host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        #2 host_req = '0;
        d = host_rdata;
    endtask : rd
    // Ten-bit settings go out as upper byte, then low byte.
    task automatic wr10(input logic [7:0] a, input logic [9:0] v);
        wr(a, v[9:2]);
        wr(a + 8'h01, {6'h00, v[1:0]});
    endtask : wr10
endmodule : mbr_host_model
`default_nettype wire

// file: verification/test_mbr_monitor.sv
// Self-checking bench for the monitor register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module test_mbr_monitor;
    import mbr_pkg::*;
    logic       sys_clk, reset, on_pin, rev_pin, brk_pin, in_gate, or_gate;
    logic       alert_o, alert_oe_n;
    logic [1:0] gpio_in, gpio_o, gpio_oe_n;
    logic [7:0] host_rdata;
    mbr_req_t   host_req;
    mbr_adc_t   adc_in;
    int         failures = 0;
    int         n_checks = 0;
    mbr_monitor #(.REV_UNIT_CYCLES(4)) i_dut (.sys_clk(sys_clk), .reset(reset),
        .host_req(host_req), .host_rdata(host_rdata), .adc_in(adc_in),
        .on_cmp_pin(on_pin), .reverse_current_pin(rev_pin), .breaker_trip_pin(brk_pin),
        .gpio_in(gpio_in), .input_switch_gate(in_gate), .oring_switch_gate(or_gate),
        .alert_o(alert_o), .alert_oe_n(alert_oe_n), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n));
    mbr_host_model i_host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata(host_rdata));
    task automatic conclude;
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : wait_cyc
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        `CHK(d, e)
    endtask : chk_rd
    task automatic conv(input logic [1:0] ch, input logic [9:0] v);
        @(posedge sys_clk);
        #2 adc_in = '{valid: 1'b1, chan: ch, data: v};
        @(posedge sys_clk);
        #2 adc_in.valid = 1'b0;
    endtask : conv
    task automatic check_reset_values;
        chk_rd(A_POST, 8'h19);
        chk_rd(A_REVT, 8'h03);
        chk_rd(A_MM_LO, 8'hff);
        chk_rd(A_MM_LO + 8'h01, 8'h03);
        chk_rd(A_THR_LO, 8'hff);
        chk_rd(A_KEY, 8'h00);
    endtask : check_reset_values
    task automatic check_trackers;
        conv(2'h1, 10'h100);
        chk_rd(8'h0c, 8'h40);
        chk_rd(8'h0e, 8'h40);
        i_host.wr(A_PKHLD, 8'h02);
        conv(2'h1, 10'h3f0);
        chk_rd(8'h0e, 8'h40);
        i_host.wr(A_PKCLR, 8'h02);
        chk_rd(8'h0c, 8'hff);
        chk_rd(8'h0e, 8'h00);
        i_host.wr(A_PKCLR, 8'h00);
        i_host.wr(A_PKHLD, 8'h00);
    endtask : check_trackers
    task automatic check_warnings;
        i_host.wr10(A_THR_LO, 10'h080);
        conv(2'h0, 10'h080);
        chk_rd(A_OCW, 8'h00);
        conv(2'h0, 10'h100);
        chk_rd(A_OCW, 8'h01);
        chk_rd(A_OCW, 8'h00);
        i_host.wr(A_OCW, 8'h02);
        conv(2'h0, 10'h100);
        wait_cyc(2);
        `CHK(alert_oe_n, 1'b0)
        chk_rd(A_OCW, 8'h03);
        i_host.wr(A_DGI, 8'h01);
        chk_rd(A_DGI, 8'h01);
        conv(2'h0, 10'h000);
        conv(2'h0, 10'h100);
        chk_rd(A_OCW, 8'h02);
        conv(2'h0, 10'h100);
        chk_rd(A_OCW, 8'h03);
        i_host.wr(A_GPOE, 8'hff);
        wait_cyc(2);
        `CHK(gpio_oe_n, 2'b00)
        chk_rd(A_GPOE, 8'h03);
    endtask : check_warnings
    task automatic check_enable;
        i_host.wr(A_CHEN, 8'h0f);
        wait_cyc(4);
        `CHK({in_gate, or_gate}, 2'b11)
        on_pin = 1'b1;
        i_host.wr(A_CHEN, 8'h02);
        wait_cyc(4);
        `CHK(in_gate, 1'b0)
        i_host.wr(A_CHEN, 8'h00);
        wait_cyc(4);
        `CHK(in_gate, 1'b1)
        on_pin = 1'b0;
    endtask : check_enable
    task automatic check_history;
        i_host.wr(A_CHEN, 8'h01);
        conv(2'h0, 10'h2c5);
        conv(2'h0, 10'h0d3);
        chk_rd(A_BUFCS, 8'hb1);
        chk_rd(A_BUFCS, 8'h01);
        chk_rd(A_BUFCS, 8'h34);
        chk_rd(A_RDW, 8'h00);
        chk_rd(A_BUFCS, 8'hb1);
        chk_rd(A_BUFCS, 8'h01);
        i_host.wr(A_RDW, 8'h01);
        chk_rd(A_BUFCS, 8'hb1);
        chk_rd(A_BUFCS, 8'h34);
        i_host.wr(A_CHEN, 8'h00);
    endtask : check_history
    task automatic check_force;
        i_host.wr(A_FOSET, 8'h01);
        wait_cyc(4);
        `CHK(in_gate, 1'b0)
        i_host.wr(A_KEY, FO_KEY);
        i_host.wr(A_FOSET, 8'h03);
        brk_pin = 1'b1;
        rev_pin = 1'b1;
        wait_cyc(6);
        `CHK({in_gate, or_gate}, 2'b11)
        i_host.wr(A_FOSET, 8'h04);
        chk_rd(A_KEY, 8'h00);
        chk_rd(A_FOSET, 8'h00);
        chk_rd(A_THR_LO, 8'hff);
        chk_rd(A_BUFEN, 8'h07);
        wait_cyc(20);
        chk_rd(A_BUFEN, 8'h05);
    endtask : check_force
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #125000;
        failures++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        {on_pin, rev_pin, brk_pin} = 3'h0;
        gpio_in = 2'h3;
        adc_in = '0;
        repeat (2) @(posedge sys_clk);
        #2 reset = 1'b0;
        check_reset_values();
        check_trackers();
        check_warnings();
        check_enable();
        check_history();
        check_force();
        conclude();
    end
endmodule : test_mbr_monitor
`default_nettype wire
